// ==== fsps_pkg.sv ====
package fsps_pkg;
    // register byte addresses on the avalon bus
    localparam logic [7:0] ADDR_TRIGGER  = 8'ha4;
    localparam logic [7:0] ADDR_UPDATE   = 8'ha5;
    localparam logic [7:0] ADDR_ADDR_LO  = 8'ha6;
    localparam logic [7:0] ADDR_ADDR_HI  = 8'ha7;
    localparam logic [7:0] ADDR_DATA     = 8'hae;
    localparam logic [7:0] ADDR_COMMAND  = 8'haf;
    localparam logic [7:0] ADDR_CHIPCTL  = 8'h9f;
    localparam logic [7:0] ADDR_UNLOCK   = 8'hc7;
    localparam logic [7:0] ADDR_STATUS   = 8'hc8;
    // reset values
    localparam logic [7:0] RST_COMMAND   = 8'h30;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    // unlock bytes
    localparam logic [7:0] UNLOCK_FIRST  = 8'haa;
    localparam logic [7:0] UNLOCK_SECOND = 8'h55;
    // field positions
    localparam int GO_BIT       = 0;
    localparam int ENABLE_BIT   = 0;
    localparam int FAULT_BIT    = 6;
    localparam int BOD_INHIBIT_BIT = 3;
    // block select codes
    localparam logic [1:0] BLK_APP  = 2'h0;
    localparam logic [1:0] BLK_BOOT = 2'h1;
    localparam logic [1:0] BLK_CFG  = 2'h3;
    // function codes
    localparam logic [3:0] FN_READ    = 4'h0;
    localparam logic [3:0] FN_PROGRAM = 4'h1;
    localparam logic [3:0] FN_ERASE   = 4'h2;
    localparam logic [3:0] FN_UID     = 4'h4;
    localparam logic [3:0] FN_COMPANY = 4'hb;
    localparam logic [3:0] FN_DEVID   = 4'hc;
    // memory sizes
    localparam int APP_BYTES  = 1024;
    localparam int BOOT_BYTES = 256;
    localparam int PAGE_BYTES = 128;
    localparam int CFG_BYTES  = 5;
    localparam int UID_BYTES  = 12;
    localparam logic [7:0] ERASED = 8'hff;
    // operation timing
    localparam int OP_TIME_NS   = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [7:0] OP_CYCLES = 8'(OP_TIME_NS / CLK_PERIOD_NS);
    localparam logic [2:0] OSC_START_CYCLES = 3'h4;
    typedef enum logic [1:0] {FSPS_IDLE, FSPS_OSC, FSPS_BUSY, FSPS_ERASE} fsps_state_t;
endpackage

// ==== fsps_sync.sv ====
`timescale 1ns/1ps
module fsps_sync (
    input  wire logic sys_clk_in,
    input  wire logic nrst_in,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    // two stage synchroniser
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ==== fsps_unlock.sv ====
`timescale 1ns/1ps
module fsps_unlock (
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    output logic            open_out
);
    logic got_first_q;
    // unlock window: 0xaa then 0x55, opens for exactly the next write
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            got_first_q <= 1'b0;
            open_out    <= 1'b0;
        end
        else if (wr_in)
        begin
            if (addr_in == fsps_pkg::ADDR_UNLOCK)
            begin
                open_out    <= got_first_q && wdata_in == fsps_pkg::UNLOCK_SECOND;
                got_first_q <= wdata_in == fsps_pkg::UNLOCK_FIRST;
            end
            else
            begin
                open_out    <= 1'b0;
                got_first_q <= 1'b0;
            end
        end
    end
endmodule

// ==== fsps_top.sv ====
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
// What this block does
// RULE1 - writing 1 to go bit at trigger register 0xa4 starts the operation
// RULE2 - cpu held stalled while the operation runs, resumes after completion
// RULE3 - go bit clears itself at end and always reads as zero
// RULE4 - firmware writes 0xaa then 0x55 to unlock before setting go
// RULE5 - firmware disables interrupts around an operation
// RULE6 - block select: 00 application, 01 boot, 11 configuration bytes
// RULE7 - function 0010 erase, 0001 program with operate enable; 0000 read
// RULE8 - company id ignores address; device id low at 0, high at 1
// RULE9 - unique code read returns one byte per address 0 to 0xb
// RULE10 - configuration erase at address 0 clears all bytes; erase leaves 0xff
// RULE11 - configuration bytes 0,1,2,4 live at addresses 0,1,2,4
// RULE12 - firmware clears enable when done so stray triggers do nothing
// RULE13 - oscillator runs while enabled; stops when cleared under external clock
// RULE14 - enable bit writes accepted only right after the unlock sequence
// RULE15 - security lock does not block self programming
// RULE16 - firmware never erases or programs its executing page
// RULE17 - fault flag set for bad address, command, disabled block, brown-out
// RULE18 - per block update enable inhibits erase and program when clear
// RULE19 - erase clears the 128 byte page holding the address
// RULE20 - setting enable turns the fast oscillator on
module fsps_top #(
    parameter logic [7:0] COMPANY_ID = 8'h5a,  // arbitrary value
    parameter logic [7:0] DEVID_LO   = 8'h11,  // arbitrary value
    parameter logic [7:0] DEVID_HI   = 8'h22   // arbitrary value
) (
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        brownout_in,
    input  wire logic        ext_clock_sel_in,
    input  wire logic        security_lock_in,
    output logic             cpu_hold_out,
    output logic             fast_osc_on_out,
    output logic             busy_out
);
    fsps_pkg::fsps_state_t state_q;
    logic [7:0]  command_q;
    logic [7:0]  addr_lo_q;
    logic [7:0]  addr_hi_q;
    logic [7:0]  data_q;
    logic [2:0]  update_en_q;
    logic        enable_q;
    logic        fault_q;
    logic        bod_inhibit_q;
    logic [7:0]  count_q;
    logic [6:0]  erase_idx_q;
    logic [2:0]  osc_cnt_q;
    logic        ack_q;
    logic        open_w;
    logic        brownout_s;
    logic        wr_w;
    logic        rd_w;
    logic        go_w;
    logic [15:0] addr_w;
    logic        legal_w;
    logic        is_write_op_w;
    logic [7:0]  app_mem   [fsps_pkg::APP_BYTES];
    logic [7:0]  boot_mem  [fsps_pkg::BOOT_BYTES];
    logic [7:0]  cfg_mem   [fsps_pkg::CFG_BYTES];
    logic [7:0]  uid_rom   [fsps_pkg::UID_BYTES];

    // bus handshake: each access takes one wait cycle, except a go write or one made while the sequencer runs
    assign wr_w   = avs_write && !ack_q;
    assign rd_w   = avs_read && !ack_q;
    assign addr_w = {addr_hi_q, addr_lo_q};

    fsps_sync u_bod_sync (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .async_in   (brownout_in),
        .sync_out   (brownout_s)
    );

    fsps_unlock u_unlock (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .wr_in      (wr_w),
        .addr_in    (avs_address),
        .wdata_in   (avs_writedata[7:0]),
        .open_out   (open_w)
    );

    // command legality check for block, function and address
    function automatic logic cmd_ok(input logic [7:0] cmd, input logic [15:0] a);
        logic [1:0] blk;
        logic [3:0] fn;
        logic       oe;
        blk = cmd[7:6];
        fn  = cmd[3:0];
        oe  = cmd[5];
        cmd_ok = 1'b0;
        if (cmd[4])
            cmd_ok = 1'b0;                                      // [RULE7]
        else if (fn == fsps_pkg::FN_COMPANY)
            cmd_ok = !oe;                                       // [RULE8]
        else if (fn == fsps_pkg::FN_DEVID)
            cmd_ok = !oe && a < 16'h0002;                       // [RULE8]
        else if (fn == fsps_pkg::FN_UID)
            cmd_ok = !oe && a < 16'(fsps_pkg::UID_BYTES);       // [RULE9]
        else if ((fn == fsps_pkg::FN_READ && !oe) ||
                 (fn == fsps_pkg::FN_PROGRAM && oe))
        begin
            case (blk)                                          // [RULE6]
                fsps_pkg::BLK_APP:  cmd_ok = a < 16'(fsps_pkg::APP_BYTES);
                fsps_pkg::BLK_BOOT: cmd_ok = a < 16'(fsps_pkg::BOOT_BYTES);
                fsps_pkg::BLK_CFG:  cmd_ok = a < 16'h0005 && a != 16'h0003; // [RULE11]
                default:            cmd_ok = 1'b0;
            endcase
        end
        else if (fn == fsps_pkg::FN_ERASE && oe)
        begin
            case (blk)
                fsps_pkg::BLK_APP:  cmd_ok = a < 16'(fsps_pkg::APP_BYTES);
                fsps_pkg::BLK_BOOT: cmd_ok = a < 16'(fsps_pkg::BOOT_BYTES);
                fsps_pkg::BLK_CFG:  cmd_ok = a == 16'h0000;     // [RULE10]
                default:            cmd_ok = 1'b0;
            endcase
        end
    endfunction

    // erase or program aimed at an allowed block, not inhibited by brown-out
    assign is_write_op_w = command_q[5];
    assign legal_w = cmd_ok(command_q, addr_w) && !(is_write_op_w && (
        !update_en_q[command_q[7] ? 2 : (command_q[6] ? 1 : 0)] ||     // [RULE18]
        (bod_inhibit_q && brownout_s)));                               // [RULE17]
    // security_lock_in intentionally not consulted [RULE15]
    assign go_w = wr_w && avs_address == fsps_pkg::ADDR_TRIGGER && open_w &&
                  avs_writedata[fsps_pkg::GO_BIT] && enable_q &&       // [RULE1] [RULE14]
                  state_q == fsps_pkg::FSPS_IDLE;

    // unique code contents, fixed per die
    always_comb
    begin
        for (int i = 0; i < fsps_pkg::UID_BYTES; i++)
            uid_rom[i] = 8'(8'h3c ^ (i * 8'h17));
    end

    // bus acknowledge toggles so each access sees at least one waitrequest cycle
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read || avs_write) && !ack_q;
    end

    // waitrequest: high while request pending, low in the acknowledging cycle
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q &&
                                 !(go_w || state_q != fsps_pkg::FSPS_IDLE));  // [RULE2]
    end

    // plain configuration registers
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            command_q <= fsps_pkg::RST_COMMAND;
            addr_lo_q <= fsps_pkg::RST_ZERO;
            addr_hi_q <= fsps_pkg::RST_ZERO;
            bod_inhibit_q <= 1'b1;
        end
        else if (wr_w && state_q == fsps_pkg::FSPS_IDLE)
        begin
            case (avs_address)
                fsps_pkg::ADDR_COMMAND: command_q <= avs_writedata[7:0];
                fsps_pkg::ADDR_ADDR_LO: addr_lo_q <= avs_writedata[7:0];
                fsps_pkg::ADDR_ADDR_HI: addr_hi_q <= avs_writedata[7:0];
                fsps_pkg::ADDR_STATUS:
                    bod_inhibit_q <= avs_writedata[fsps_pkg::BOD_INHIBIT_BIT];
                default: ;
            endcase
        end
    end

    // protected update enables and function enable
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            update_en_q <= 3'h0;
            enable_q    <= 1'b0;
        end
        else if (wr_w && open_w && state_q == fsps_pkg::FSPS_IDLE)
        begin
            if (avs_address == fsps_pkg::ADDR_UPDATE)
                update_en_q <= avs_writedata[2:0];                        // [RULE18]
            if (avs_address == fsps_pkg::ADDR_CHIPCTL)
                enable_q <= avs_writedata[fsps_pkg::ENABLE_BIT];          // [RULE14]
        end
    end

    // fault flag: hardware set wins over software clear
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            fault_q <= 1'b0;
        else if (go_w && !legal_w)
            fault_q <= 1'b1;                                               // [RULE17]
        else if (wr_w && avs_address == fsps_pkg::ADDR_CHIPCTL &&
                 !avs_writedata[fsps_pkg::FAULT_BIT])
            fault_q <= 1'b0;
    end

    // sequencer: oscillator settle, then timed busy, erase walks the page
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q     <= fsps_pkg::FSPS_IDLE;
            count_q     <= 8'h00;
            erase_idx_q <= 7'h00;
        end
        else
        begin
            case (state_q)
                fsps_pkg::FSPS_IDLE:
                    if (go_w && legal_w)
                    begin
                        state_q     <= fsps_pkg::FSPS_OSC;
                        count_q     <= fsps_pkg::OP_CYCLES;
                        erase_idx_q <= 7'h00;
                    end
                fsps_pkg::FSPS_OSC:
                    if (osc_cnt_q == fsps_pkg::OSC_START_CYCLES)
                        state_q <= (command_q[3:0] == fsps_pkg::FN_ERASE) ?
                                   fsps_pkg::FSPS_ERASE : fsps_pkg::FSPS_BUSY;
                fsps_pkg::FSPS_ERASE:
                begin
                    erase_idx_q <= erase_idx_q + 7'h01;                    // [RULE19]
                    if (erase_idx_q == 7'h7f)
                        state_q <= fsps_pkg::FSPS_BUSY;
                end
                fsps_pkg::FSPS_BUSY:
                begin
                    count_q <= count_q - 8'h01;
                    if (count_q == 8'h01)
                        state_q <= fsps_pkg::FSPS_IDLE;                    // [RULE3]
                end
                default: state_q <= fsps_pkg::FSPS_IDLE;
            endcase
        end
    end

    // oscillator settle counter
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            osc_cnt_q <= 3'h0;
        else if (state_q == fsps_pkg::FSPS_OSC)
            osc_cnt_q <= osc_cnt_q + 3'h1;
        else
            osc_cnt_q <= 3'h0;
    end

    // flash arrays: program, erase; no reset on memory contents
    always_ff @(posedge sys_clk_in)
    begin
        if (state_q == fsps_pkg::FSPS_ERASE)
        begin
            case (command_q[7:6])                                          // [RULE10]
                fsps_pkg::BLK_APP:
                    app_mem[{addr_w[9:7], erase_idx_q}] <= fsps_pkg::ERASED;
                fsps_pkg::BLK_BOOT:
                    boot_mem[{addr_w[7], erase_idx_q}] <= fsps_pkg::ERASED;
                default:
                    if (erase_idx_q < 7'(fsps_pkg::CFG_BYTES))
                        cfg_mem[erase_idx_q[2:0]] <= fsps_pkg::ERASED;
            endcase
        end
        else if (state_q == fsps_pkg::FSPS_OSC && osc_cnt_q == 3'h0 &&
                 command_q[3:0] == fsps_pkg::FN_PROGRAM)
        begin
            case (command_q[7:6])                                          // [RULE7]
                fsps_pkg::BLK_APP:  app_mem[addr_w[9:0]]  <= app_mem[addr_w[9:0]] & data_q;
                fsps_pkg::BLK_BOOT: boot_mem[addr_w[7:0]] <= boot_mem[addr_w[7:0]] & data_q;
                default:            cfg_mem[addr_w[2:0]]  <= cfg_mem[addr_w[2:0]] & data_q;
            endcase                                                        // [RULE11]
        end
    end

    // data register: software write or read result
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            data_q <= fsps_pkg::RST_ZERO;
        else if (state_q == fsps_pkg::FSPS_OSC && osc_cnt_q == 3'h0)
        begin
            case (command_q[3:0])
                fsps_pkg::FN_COMPANY: data_q <= COMPANY_ID;                // [RULE8]
                fsps_pkg::FN_DEVID:   data_q <= addr_w[0] ? DEVID_HI : DEVID_LO;
                fsps_pkg::FN_UID:     data_q <= uid_rom[addr_w[3:0]];      // [RULE9]
                fsps_pkg::FN_READ:
                    case (command_q[7:6])
                        fsps_pkg::BLK_APP:  data_q <= app_mem[addr_w[9:0]];
                        fsps_pkg::BLK_BOOT: data_q <= boot_mem[addr_w[7:0]];
                        default:            data_q <= cfg_mem[addr_w[2:0]];
                    endcase
                fsps_pkg::FN_ERASE:   data_q <= fsps_pkg::ERASED;
                default: ;
            endcase
        end
        else if (wr_w && avs_address == fsps_pkg::ADDR_DATA && state_q == fsps_pkg::FSPS_IDLE)
            data_q <= avs_writedata[7:0];
    end

    // read mux; trigger always reads zero
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            avs_readdata <= 32'h0000_0000;
        else if (rd_w)
        begin
            case (avs_address)
                fsps_pkg::ADDR_TRIGGER: avs_readdata <= 32'h0000_0000;     // [RULE3]
                fsps_pkg::ADDR_UPDATE:  avs_readdata <= {29'h0, update_en_q};
                fsps_pkg::ADDR_ADDR_LO: avs_readdata <= {24'h0, addr_lo_q};
                fsps_pkg::ADDR_ADDR_HI: avs_readdata <= {24'h0, addr_hi_q};
                fsps_pkg::ADDR_DATA:    avs_readdata <= {24'h0, data_q};
                fsps_pkg::ADDR_COMMAND: avs_readdata <= {24'h0, command_q};
                fsps_pkg::ADDR_CHIPCTL: avs_readdata <= {25'h0, fault_q, 5'h0, enable_q};
                fsps_pkg::ADDR_STATUS:  avs_readdata <= {28'h0, bod_inhibit_q, 3'h0};
                default:                avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // status outputs: hold, busy, oscillator request
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cpu_hold_out    <= 1'b0;
            busy_out        <= 1'b0;
            fast_osc_on_out <= 1'b0;
        end
        else
        begin
            cpu_hold_out    <= (go_w && legal_w) ||
                               (state_q != fsps_pkg::FSPS_IDLE &&
                                !(state_q == fsps_pkg::FSPS_BUSY && count_q == 8'h01)); // [RULE2]
            busy_out        <= state_q != fsps_pkg::FSPS_IDLE;
            fast_osc_on_out <= enable_q || !ext_clock_sel_in ||
                               state_q != fsps_pkg::FSPS_IDLE;             // [RULE13] [RULE20]
        end
    end
endmodule

// ==== fsps_props.sv ====
`timescale 1ns/1ps
module fsps_props (
    input wire logic        sys_clk_in,
    input wire logic        nrst_in,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        brownout_in,
    input wire logic        busy_out,
    input wire logic        cpu_hold_out,
    input wire logic        fast_osc_on_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    // a start is always caused by a go write still held on the bus
    a_start_cause: assert property (
        $rose(busy_out) |-> avs_write && avs_address == fsps_pkg::ADDR_TRIGGER
            && avs_writedata[0]) else $error("sequencer started without go");
    // cpu stall only while the sequencer works, and the bus stalls with it
    a_hold_busy: assert property (cpu_hold_out |=> busy_out)
        else $error("hold without busy");
    a_wait_hold: assert property (cpu_hold_out |-> avs_waitrequest)
        else $error("bus answered during hold");
    a_hold_ends: assert property (
        $rose(cpu_hold_out) |-> ##[1:400] !cpu_hold_out) else $error("hold too long");
    a_hold_resume: assert property (
        $fell(cpu_hold_out) |-> ##[0:8] !avs_waitrequest) else $error("no resume");
    a_ack_single: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("answer longer than a cycle");
    a_rd_trig_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == fsps_pkg::ADDR_TRIGGER
            |-> avs_readdata == 32'h0) else $error("trigger read not zero");
    a_osc_busy: assert property (busy_out |-> fast_osc_on_out)
        else $error("oscillator off while busy");

    // main scenarios
    c_hold: cover property ($rose(cpu_hold_out));
    c_brown: cover property (brownout_in && avs_write);
    c_trig_rd: cover property (avs_read && !avs_waitrequest
        && avs_address == fsps_pkg::ADDR_TRIGGER);
endmodule

bind fsps_top fsps_props fsps_props_inst (.sys_clk_in, .nrst_in, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .brownout_in, .busy_out,
    .cpu_hold_out, .fast_osc_on_out);

// ==== fsps_cpu_model.sv ====
`timescale 1ns/1ps
module fsps_cpu_model (
    input  wire logic        sys_clk_in,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic [7:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    output logic             timeout_out
);
    // idle bus at time zero
    initial
    begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        timeout_out = 1'b0;
    end

    // one avalon cycle, held until waitrequest is seen low
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= rd;
        avs_write <= !rd;
        do
        begin
            @(posedge sys_clk_in);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 1000);
        if (avs_waitrequest !== 1'b0)
            timeout_out = 1'b1;
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;  // released lines toggle
        avs_writedata <= ~{24'h0, d};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(1'b0, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b1, a, 8'h00, q);
    endtask

    // protected write: unlock pair then the very next write
    task automatic prot(input logic [7:0] a, input logic [7:0] d);
        wr(fsps_pkg::ADDR_UNLOCK, fsps_pkg::UNLOCK_FIRST);
        wr(fsps_pkg::ADDR_UNLOCK, fsps_pkg::UNLOCK_SECOND);
        wr(a, d);
    endtask

    // trigger with interrupts notionally off; nothing else runs meanwhile
    task automatic go();
        prot(fsps_pkg::ADDR_TRIGGER, 8'h01);
    endtask
endmodule

// ==== fsps_top_tb.sv ====
`timescale 1ns/1ps
module fsps_top_tb;
    localparam logic [7:0] CO_ID = 8'h3c;  // arbitrary value
    localparam logic [7:0] DV_LO = 8'h96;  // arbitrary value
    localparam logic [7:0] DV_HI = 8'h69;  // arbitrary value
    logic        sys_clk_in;
    logic        nrst_in;
    logic        brownout_in;
    logic        ext_clock_sel_in;
    logic        security_lock_in;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cpu_hold_out;
    logic        fast_osc_on_out;
    logic        busy_out;
    logic        timeout_out;
    logic [31:0] r;
    int          n_mismatch;
    int          cmp_count;

    fsps_top #(.COMPANY_ID(CO_ID), .DEVID_LO(DV_LO), .DEVID_HI(DV_HI)) fsps_top_inst (
        .sys_clk_in, .nrst_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .brownout_in, .ext_clock_sel_in,
        .security_lock_in, .cpu_hold_out, .fast_osc_on_out, .busy_out);
    fsps_cpu_model fsps_cpu_model_inst (.sys_clk_in, .avs_waitrequest, .avs_readdata,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .timeout_out);

    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // a stuck bus ends the run
    always @(posedge timeout_out)
    begin
        n_mismatch++;
        test_done();
    end

    // load command, address, data; fire; fetch the data byte
    task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
        fsps_cpu_model_inst.wr(fsps_pkg::ADDR_COMMAND, c);
        fsps_cpu_model_inst.wr(fsps_pkg::ADDR_ADDR_LO, a[7:0]);
        fsps_cpu_model_inst.wr(fsps_pkg::ADDR_ADDR_HI, a[15:8]);
        fsps_cpu_model_inst.wr(fsps_pkg::ADDR_DATA, d);
        fsps_cpu_model_inst.go();
        fsps_cpu_model_inst.rd(fsps_pkg::ADDR_DATA, r);
    endtask

    task automatic opc(input logic [7:0] c, input logic [15:0] a, input logic [7:0] e);
        op(c, a, 8'h00);
        chk(r, {24'h0, e});
    endtask

    // compare the fault flag, then clear it keeping the enable set
    task automatic flt(input logic e);
        fsps_cpu_model_inst.rd(fsps_pkg::ADDR_CHIPCTL, r);
        chk({31'h0, r[fsps_pkg::FAULT_BIT]}, {31'h0, e});
        fsps_cpu_model_inst.prot(fsps_pkg::ADDR_CHIPCTL, 8'h01);
    endtask

    // main sequence; no target is the page the firmware runs
    initial
    begin
        nrst_in = 1'b0;
        brownout_in = 1'b0;
        ext_clock_sel_in = 1'b1;
        security_lock_in = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (16) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        fsps_cpu_model_inst.rd(fsps_pkg::ADDR_COMMAND, r);
        chk(r, {24'h0, fsps_pkg::RST_COMMAND});
        fsps_cpu_model_inst.rd(fsps_pkg::ADDR_TRIGGER, r);
        chk(r, 32'h0);
        // enable refused without unlock, taken after it
        fsps_cpu_model_inst.wr(fsps_pkg::ADDR_CHIPCTL, 8'h01);
        fsps_cpu_model_inst.rd(fsps_pkg::ADDR_CHIPCTL, r);
        chk({31'h0, r[0]}, 32'h0);
        chk({31'h0, fast_osc_on_out}, 32'h0);
        fsps_cpu_model_inst.prot(fsps_pkg::ADDR_CHIPCTL, 8'h01);
        @(negedge sys_clk_in);
        chk({31'h0, fast_osc_on_out}, 32'h1);
        opc(8'h0b, 16'h5a5a, CO_ID);
        opc(8'h0c, 16'h0000, DV_LO);
        opc(8'h0c, 16'h0001, DV_HI);
        op(8'h22, 16'h0100, 8'hff);
        flt(1'b1);
        fsps_cpu_model_inst.prot(fsps_pkg::ADDR_UPDATE, 8'h07);
        brownout_in <= 1'b1;
        op(8'h22, 16'h0100, 8'hff);
        brownout_in <= 1'b0;
        flt(1'b1);
        // application and boot page erase, program, read back
        op(8'h22, 16'h0140, 8'hff);
        op(8'h21, 16'h0101, 8'h55);
        opc(8'h00, 16'h0101, 8'h55);
        opc(8'h00, 16'h0100, 8'hff);
        opc(8'h00, 16'h017f, 8'hff);
        op(8'h62, 16'h0000, 8'hff);
        op(8'h61, 16'h0000, 8'ha5);
        opc(8'h40, 16'h0000, 8'ha5);
        // configuration bytes with the lock input active, boot update off
        fsps_cpu_model_inst.prot(fsps_pkg::ADDR_UPDATE, 8'h05);
        security_lock_in <= 1'b1;
        op(8'he2, 16'h0000, 8'hff);
        op(8'he1, 16'h0004, 8'h3c);
        opc(8'hc0, 16'h0004, 8'h3c);
        opc(8'hc0, 16'h0002, 8'hff);
        flt(1'b0);
        for (int i = 0; i < fsps_pkg::UID_BYTES; i++)
            op(8'hc4, 16'(i), 8'h00);
        flt(1'b0);
        op(8'h00, 16'h0400, 8'h00);
        flt(1'b1);
        op(8'h07, 16'h0000, 8'h00);
        flt(1'b1);
        // disable under external clock; a stray go then does nothing
        ext_clock_sel_in <= 1'b1;
        fsps_cpu_model_inst.prot(fsps_pkg::ADDR_CHIPCTL, 8'h00);
        @(negedge sys_clk_in);
        chk({31'h0, fast_osc_on_out}, 32'h0);
        fsps_cpu_model_inst.go();
        @(negedge sys_clk_in);
        chk({31'h0, busy_out}, 32'h0);
        chk({31'h0, cpu_hold_out}, 32'h0);
        fsps_cpu_model_inst.rd(fsps_pkg::ADDR_CHIPCTL, r);
        chk({31'h0, r[fsps_pkg::FAULT_BIT]}, 32'h0);
        test_done();
    end
endmodule
